// File: design/mcs_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module mcs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   clk_en_i,
  // Fill side
  mcs_stream_if.snk   wr_if,
  // Drain side
  mcs_stream_if.src   rd_if
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [LW-1:0]    cnt_ff;
  logic             wr_go;
  logic             rd_go;

  assign wr_if.ready = (cnt_ff != LW'(DEPTH));
  assign rd_if.valid = (cnt_ff != '0);
  assign rd_if.data  = mem_ff[rd_ptr_ff];
  assign wr_go       = wr_if.valid && wr_if.ready && clk_en_i;
  assign rd_go       = rd_if.valid && rd_if.ready && clk_en_i;

  always_ff @(posedge clk_i) begin
    if (wr_go) begin
      mem_ff[wr_ptr_ff] <= wr_if.data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (wr_go) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (rd_go) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (wr_go && !rd_go) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (rd_go && !wr_go) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  a_fifo_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_ff <= LW'(DEPTH)) else $error("fifo count above depth");

endmodule

// File: design/mcs_path.sv
// Sample store and host transfer path for four simultaneous converters
`timescale 1ns/1ps
module mcs_path
  import mcs_pkg::*;
#(
  parameter int STORE_DEPTH_P = mcs_pkg::STORE_DEPTH,
  parameter int RES_BITS      = mcs_pkg::RES_DEF,
  parameter int FIFO_DEPTH    = mcs_pkg::XFER_DEPTH,
  parameter int MAX_ACQ       = mcs_pkg::MAX_ACQ_SAMPLES
) (
  // Clock and reset
  input  wire logic                                   ref_clk_i,
  input  wire logic                                   arst_n_i,
  input  wire logic                                   clk_en_i,
  // Acquisition control
  input  wire logic                                   acq_start_i,
  input  wire logic [2:0]                             ch_cnt_i,
  input  wire logic [mcs_pkg::CNT_W-1:0]              acq_len_i,
  // Converters
  input  wire logic                                   smp_strobe_i,
  input  wire logic [mcs_pkg::NUM_CH*mcs_pkg::ADC_W-1:0] adc_data_i,
  input  wire logic                                   trig_det_i,
  input  wire logic [mcs_pkg::DI_W-1:0]               dig_in_i,
  // Transfer side
  output logic [mcs_pkg::WORD_W-1:0]                  dma_data_o,
  output logic                                        dma_valid_o,
  input  wire logic                                   dma_ready_i,
  // Status
  output logic                                        busy_o,
  output logic                                        done_o,
  output logic                                        overflow_o,
  output logic [15:0]                                 chan_share_o
);
  import mcs_pkg::*;

  localparam int AW = $clog2(STORE_DEPTH_P);
  localparam int LW = AW + 1;
  localparam logic [SAMPLE_W-1:0] RES_MASK =
    ~((SAMPLE_W'(1) << (SAMPLE_W - RES_BITS)) - SAMPLE_W'(1));

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ************************************************************
  // Declarations
  // ************************************************************
  mcs_state_t           state_ff;
  logic [2:0]           nch_ff;
  logic [CNT_W-1:0]     len_ff;
  logic [CNT_W-1:0]     acq_cnt_ff;
  logic [SAMPLE_W-1:0]  stage_ff [NUM_CH];
  logic [2:0]           ser_cnt_ff;
  logic [1:0]           ser_idx_ff;
  logic [SAMPLE_W-1:0]  store_ff [STORE_DEPTH_P];
  logic [AW-1:0]        wr_ptr_ff;
  logic [AW-1:0]        rd_ptr_ff;
  logic [LW-1:0]        level_ff;
  logic [WORD_W-1:0]    pair_ff;
  logic [1:0]           pair_cnt_ff;
  logic                 ch_ok;
  logic                 start_go;
  logic                 acq_full;
  logic                 room;
  logic                 cap_go;
  logic                 drop_go;
  logic                 wr_en;
  logic                 rd_en;
  logic                 flush;
  logic                 drained;
  logic [CNT_W-1:0]     len_clip;

  mcs_stream_if #(.W(WORD_W)) push_if ();
  mcs_stream_if #(.W(WORD_W)) pop_if ();

  function automatic logic [SAMPLE_W-1:0] fmt_word(
    input logic [ADC_W-1:0] adc,
    input logic             trig,
    input logic [DI_W-1:0]  di
  );
    logic [SAMPLE_W-1:0] w;
    w = {adc, 4'h0} & RES_MASK;
    w[TRIG_BIT] = trig;
    w[DI_LSB +: DI_W] = di;
    return w;
  endfunction

  // ************************************************************
  // Control decode
  // ************************************************************
  assign ch_ok = (ch_cnt_i == CH_ONE) || (ch_cnt_i == CH_TWO)
              || (ch_cnt_i == CH_FOUR);
  assign start_go = acq_start_i && ch_ok && (acq_len_i != '0)
                 && (state_ff != MCS_RUN);
  assign len_clip = (acq_len_i > CNT_W'(MAX_ACQ)) ? CNT_W'(MAX_ACQ)
                  : acq_len_i;
  assign acq_full = (acq_cnt_ff >= len_ff);
  assign room = (level_ff <= LW'(STORE_DEPTH_P) - LW'(nch_ff))
             && (ser_cnt_ff == 3'h0);
  assign cap_go  = smp_strobe_i && (state_ff == MCS_RUN) && !acq_full && room;
  assign drop_go = smp_strobe_i && (state_ff == MCS_RUN) && !acq_full && !room;
  assign drained = acq_full && (level_ff == '0) && (ser_cnt_ff == 3'h0);

  // ************************************************************
  // Acquisition state
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MCS_IDLE;
    end else if (clk_en_i) begin
      case (state_ff)
        MCS_IDLE: begin
          if (start_go) begin
            state_ff <= MCS_RUN;
          end
        end
        MCS_RUN: begin
          if (drained && (pair_cnt_ff == 2'h0)) begin
            state_ff <= MCS_DONE;
          end
        end
        MCS_DONE: begin
          if (start_go) begin
            state_ff <= MCS_RUN;
          end
        end
        default: begin
          state_ff <= MCS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      nch_ff       <= CH_ONE;
      len_ff       <= '0;
      chan_share_o <= 16'h0;
    end else if (clk_en_i && start_go) begin
      nch_ff <= ch_cnt_i;
      len_ff <= len_clip;
      case (ch_cnt_i)
        CH_ONE:  chan_share_o <= 16'(STORE_DEPTH_P);
        CH_TWO:  chan_share_o <= 16'(STORE_DEPTH_P / 2);
        CH_FOUR: chan_share_o <= 16'(STORE_DEPTH_P / 4);
        default: chan_share_o <= 16'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      acq_cnt_ff <= '0;
    end else if (clk_en_i) begin
      if (start_go) begin
        acq_cnt_ff <= '0;
      end else if (cap_go) begin
        acq_cnt_ff <= acq_cnt_ff + CNT_W'(nch_ff);
      end
    end
  end

  // ************************************************************
  // Status outputs
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      overflow_o <= 1'b0;
      busy_o     <= 1'b0;
      done_o     <= 1'b0;
    end else if (clk_en_i) begin
      if (drop_go) begin
        overflow_o <= 1'b1;
      end else if (start_go) begin
        overflow_o <= 1'b0;
      end
      busy_o <= start_go || ((state_ff == MCS_RUN)
             && !(drained && (pair_cnt_ff == 2'h0)));
      done_o <= !start_go && ((state_ff == MCS_DONE)
             || ((state_ff == MCS_RUN) && drained && (pair_cnt_ff == 2'h0)));
    end
  end

  // ************************************************************
  // Capture and serialise
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i && cap_go) begin
      for (int i = 0; i < NUM_CH; i++) begin
        stage_ff[i] <= fmt_word(adc_data_i[i*ADC_W +: ADC_W],
                                trig_det_i, dig_in_i);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ser_cnt_ff <= 3'h0;
      ser_idx_ff <= 2'h0;
    end else if (clk_en_i) begin
      if (cap_go) begin
        ser_cnt_ff <= nch_ff;
        ser_idx_ff <= 2'h0;
      end else if (ser_cnt_ff != 3'h0) begin
        ser_cnt_ff <= ser_cnt_ff - 3'h1;
        ser_idx_ff <= ser_idx_ff + 2'h1;
      end
    end
  end

  // ************************************************************
  // Sample store
  // ************************************************************
  assign wr_en = (ser_cnt_ff != 3'h0);
  assign flush = (pair_cnt_ff == 2'h1) && drained;
  assign rd_en = (level_ff != '0) && (pair_cnt_ff != 2'h2);

  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i && wr_en) begin
      store_ff[wr_ptr_ff] <= stage_ff[ser_idx_ff];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff  <= '0;
    end else if (clk_en_i) begin
      if (wr_en) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(STORE_DEPTH_P - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (rd_en) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(STORE_DEPTH_P - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (wr_en && !rd_en) begin
        level_ff <= level_ff + 1'b1;
      end else if (rd_en && !wr_en) begin
        level_ff <= level_ff - 1'b1;
      end
    end
  end

  // ************************************************************
  // Pairing into bus words
  // ************************************************************
  assign push_if.valid = (pair_cnt_ff == 2'h2) || flush;
  assign push_if.data  = pair_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pair_ff     <= '0;
      pair_cnt_ff <= 2'h0;
    end else if (clk_en_i) begin
      if (push_if.valid && push_if.ready) begin
        pair_cnt_ff <= 2'h0;
        pair_ff     <= '0;
      end else if (rd_en) begin
        if (pair_cnt_ff == 2'h0) begin
          pair_ff[SAMPLE_W-1:0] <= store_ff[rd_ptr_ff];
        end else begin
          pair_ff[WORD_W-1:SAMPLE_W] <= store_ff[rd_ptr_ff];
        end
        pair_cnt_ff <= pair_cnt_ff + 2'h1;
      end
    end
  end

  // ************************************************************
  // Transfer queue and output stage
  // ************************************************************
  mcs_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i    (ref_clk_i),
    .rst_n_i  (rst_n),
    .clk_en_i (clk_en_i),
    .wr_if    (push_if),
    .rd_if    (pop_if)
  );

  assign pop_if.ready = !dma_valid_o || dma_ready_i;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dma_valid_o <= 1'b0;
      dma_data_o  <= '0;
    end else if (clk_en_i) begin
      if (pop_if.valid && pop_if.ready) begin
        dma_valid_o <= 1'b1;
        dma_data_o  <= pop_if.data;
      end else if (dma_ready_i) begin
        dma_valid_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_cap4;
    cap_go && clk_en_i && (nch_ff == CH_FOUR);
  endsequence
  sequence s_run4;
    clk_en_i [*4];
  endsequence

  a_ser_four: assert property (s_cap4 ##1 s_run4 |-> ##1 ser_cnt_ff == 3'h0)
    else $error("four-channel set not stored in four cycles");
  a_ser_first: assert property (s_cap4 |=> wr_en && ser_idx_ff == 2'h0)
    else $error("serialisation does not start at channel 0");
  a_share_one: assert property ($rose(busy_o) && nch_ff == CH_ONE
    |-> chan_share_o == 16'(STORE_DEPTH_P)) else $error("single share wrong");
  a_share_multi: assert property ($rose(busy_o) && nch_ff != CH_ONE
    |-> chan_share_o == 16'(STORE_DEPTH_P / 32'(nch_ff))) else $error("share wrong");
  a_word_fmt: assert property (cap_go && clk_en_i |=>
    stage_ff[0][SAMPLE_W-1 -: RES_BITS] == $past(adc_data_i[ADC_W-1 -: RES_BITS])
    && stage_ff[1][TRIG_BIT] == $past(trig_det_i)) else $error("word format wrong");
  a_low_bits: assert property (cap_go && clk_en_i |=>
    ((stage_ff[3] & ~RES_MASK) >> (TRIG_BIT + 1)) == '0
    && stage_ff[3][DI_LSB +: DI_W] == $past(dig_in_i)) else $error("pad bits set");
  a_ovf_set: assert property (drop_go && clk_en_i |=> overflow_o)
    else $error("overflow not flagged");
  a_ovf_hold: assert property (overflow_o && !start_go |=> overflow_o)
    else $error("overflow lost");
  a_acq_cap: assert property (acq_cnt_ff <= CNT_W'(MAX_ACQ) + CNT_W'(NUM_CH))
    else $error("acquisition over cap");
  a_store_cap: assert property (level_ff <= LW'(STORE_DEPTH_P))
    else $error("store level above depth");
  a_out_hold: assert property (dma_valid_o && !dma_ready_i |=>
    dma_valid_o && $stable(dma_data_o)) else $error("output word dropped");

endmodule

// File: dv/mcs_dma_sink.sv
// Transfer-side sink model that stalls at random and keeps every word taken
`timescale 1ns/1ps
module mcs_dma_sink (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Word stream from the path
  input  wire logic        valid_i,
  input  wire logic [31:0] data_i,
  output logic             ready_o,
  // Stall control
  input  wire logic        hold_i,
  input  wire logic        en_i
);
  logic [31:0] got[$];

  // ************************************************************
  // Accept and stall
  // ************************************************************
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      if (en_i && valid_i && ready_o) begin
        got.push_back(data_i);
      end
      ready_o <= !hold_i && ($urandom_range(3) != 0);
    end
  end
endmodule

// File: dv/multichannel_adc_sample_fifo_path_tb.sv
// Self-checking bench of the multichannel sample path
`timescale 1ns/1ps
module multichannel_adc_sample_fifo_path_tb;
  import mcs_pkg::*;
  localparam int SD = 16;
  localparam int MA = 64;
  logic                    ref_clk_i;
  logic                    arst_n_i;
  logic                    clk_en_i;
  logic                    acq_start_i;
  logic [2:0]              ch_cnt_i;
  logic [CNT_W-1:0]        acq_len_i;
  logic                    smp_strobe_i;
  logic [NUM_CH*ADC_W-1:0] adc_data_i;
  logic                    trig_det_i;
  logic [DI_W-1:0]         dig_in_i;
  logic [WORD_W-1:0]       dma_data_o;
  logic                    dma_valid_o;
  logic                    dma_ready_i;
  logic                    busy_o;
  logic                    done_o;
  logic                    overflow_o;
  logic [15:0]             chan_share_o;
  logic                    hold;
  logic [15:0]             exp_q[$];
  int                      err_total;
  int                      checked;

  mcs_path #(.STORE_DEPTH_P(SD), .MAX_ACQ(MA)) mcs_path_i (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
    .acq_start_i(acq_start_i), .ch_cnt_i(ch_cnt_i), .acq_len_i(acq_len_i),
    .smp_strobe_i(smp_strobe_i), .adc_data_i(adc_data_i), .trig_det_i(trig_det_i),
    .dig_in_i(dig_in_i), .dma_data_o(dma_data_o), .dma_valid_o(dma_valid_o),
    .dma_ready_i(dma_ready_i), .busy_o(busy_o), .done_o(done_o),
    .overflow_o(overflow_o), .chan_share_o(chan_share_o)
  );

  mcs_dma_sink mcs_dma_sink_i (
    .clk_i(ref_clk_i), .rst_n_i(arst_n_i), .valid_i(dma_valid_o),
    .data_i(dma_data_o), .ready_o(dma_ready_i), .hold_i(hold), .en_i(clk_en_i)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // ************************************************************
  // Compare and close
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] pack_smp(input logic [11:0] a, input logic t,
                                           input logic [2:0] d);
    return {a, t, d};
  endfunction

  // ************************************************************
  // One acquisition: start, strobes, drain, compare
  // ************************************************************
  task automatic run_acq(input logic [2:0] n, input int len, input int nstb, input bit stall);
    int take;
    int k;
    @(posedge ref_clk_i);
    #1;
    exp_q.delete();
    mcs_dma_sink_i.got.delete();
    hold = stall;
    ch_cnt_i = n;
    acq_len_i = len[CNT_W-1:0];
    acq_start_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    acq_start_i = 1'b0;
    check("busy", 32'(busy_o), 32'h1);
    check("done", 32'(done_o), 32'h0);
    check("overflow", 32'(overflow_o), 32'h0);
    check("share", 32'(chan_share_o), 32'(SD / int'(n)));
    take = (len > MA) ? MA : len;
    take = (take + int'(n) - 1) / int'(n);
    for (int s = 0; s < nstb; s++) begin
      trig_det_i = 1'($urandom);
      dig_in_i = 3'($urandom);
      adc_data_i = {16'($urandom), 32'($urandom)};
      smp_strobe_i = 1'b1;
      for (int c = 0; c < int'(n) && s < take; c++) begin
        exp_q.push_back(pack_smp(adc_data_i[12*c +: 12], trig_det_i, dig_in_i));
      end
      @(posedge ref_clk_i);
      #1;
      smp_strobe_i = 1'b0;
      repeat (11) @(posedge ref_clk_i);
      #1;
    end
    if (stall) begin
      check("overflow set", 32'(overflow_o), 32'h1);
    end
    hold = 1'b0;
    k = 0;
    while (done_o !== 1'b1) begin
      if (k == 3000) begin
        err_total++;
        break;
      end
      smp_strobe_i = stall && (k % 12 == 0);
      clk_en_i = ($urandom_range(3) != 0);
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    smp_strobe_i = 1'b0;
    clk_en_i = 1'b1;
    repeat (40) @(posedge ref_clk_i);
    #1;
    check("busy end", 32'(busy_o), 32'h0);
    if (stall) begin
      check("overflow sticky", 32'(overflow_o), 32'h1);
    end else begin
      if (exp_q.size() % 2 == 1) begin
        exp_q.push_back(16'h0);
      end
      check("words", 32'(mcs_dma_sink_i.got.size()), 32'(exp_q.size() / 2));
      for (int i = 0; i < exp_q.size() / 2 && i < mcs_dma_sink_i.got.size(); i++) begin
        check("word", mcs_dma_sink_i.got[i], {exp_q[2*i+1], exp_q[2*i]});
      end
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [2:0] bad[3] = '{3'h3, 3'h0, 3'h5};
    logic [2:0] cnts[3] = '{CH_ONE, CH_TWO, CH_FOUR};
    logic [2:0] n;
    err_total = 0;
    checked = 0;
    void'($urandom(95716));
    arst_n_i = 1'b0;
    clk_en_i = 1'b1;
    acq_start_i = 1'b0;
    ch_cnt_i = CH_ONE;
    acq_len_i = '0;
    smp_strobe_i = 1'b0;
    adc_data_i = '0;
    trig_det_i = 1'b0;
    dig_in_i = '0;
    hold = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    #1;
    check("valid in reset", 32'(dma_valid_o), 32'h0);
    check("busy in reset", 32'(busy_o), 32'h0);
    arst_n_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    for (int i = 0; i < 3; i++) begin
      ch_cnt_i = bad[i];
      acq_len_i = 26'h8;
      acq_start_i = 1'b1;
      @(posedge ref_clk_i);
      #1;
      acq_start_i = 1'b0;
      check("busy refused", 32'(busy_o), 32'h0);
      @(posedge ref_clk_i);
      #1;
    end
    ch_cnt_i = CH_ONE;
    acq_len_i = 26'h0;
    acq_start_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    acq_start_i = 1'b0;
    check("busy zero len", 32'(busy_o), 32'h0);
    run_acq(CH_ONE, 3, 3, 1'b0);
    run_acq(CH_TWO, 2 * $urandom_range(8, 1), 10, 1'b0);
    run_acq(CH_FOUR, 100, 20, 1'b0);
    run_acq(CH_FOUR, 64, 16, 1'b1);
    for (int r = 0; r < 3; r++) begin
      n = cnts[$urandom_range(2, 0)];
      run_acq(n, int'(n) * $urandom_range(6, 1), 8, 1'b0);
    end
    complete_run();
  end
endmodule

// File: shared/mcs_pkg.sv
// Constants and types of the multichannel sample path
package mcs_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int NUM_CH   = 4;
  localparam int ADC_W    = 12;
  localparam int SAMPLE_W = 16;
  localparam int WORD_W   = 32;
  localparam int CNT_W    = 26;

  // ************************************************************
  // Store and acquisition sizes
  // ************************************************************
  localparam int BANK_DEPTH      = 16384;
  localparam int NUM_BANKS       = 2;
  localparam int STORE_DEPTH     = BANK_DEPTH * NUM_BANKS;
  localparam int MAX_ACQ_SAMPLES = 33554432;
  localparam int RES_DEF         = 12;
  localparam int XFER_DEPTH      = 4;

  // ************************************************************
  // Word layout
  // ************************************************************
  localparam int TRIG_BIT = 3;
  localparam int DI_W     = 3;
  localparam int DI_LSB   = 0;

  // ************************************************************
  // Channel count codes
  // ************************************************************
  localparam logic [2:0] CH_ONE  = 3'h1;
  localparam logic [2:0] CH_TWO  = 3'h2;
  localparam logic [2:0] CH_FOUR = 3'h4;

  typedef enum logic [2:0] {
    MCS_IDLE = 3'b001,
    MCS_RUN  = 3'b010,
    MCS_DONE = 3'b100
  } mcs_state_t;

endpackage

// File: shared/mcs_stream_if.sv
// Valid and ready stream into and out of the transfer queue
`timescale 1ns/1ps
interface mcs_stream_if #(
  parameter int W = 32
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
